//--- hw/pstd_map.svh
// register offsets, field positions, reset values for the self-test/diag register group
`ifndef PSTD_MAP_SVH
`define PSTD_MAP_SVH
// register indices; byte address is four times the index
`define PSTD_IDX_MODE    6'h16
`define PSTD_IDX_TALLY   6'h1B
`define PSTD_IDX_PKT     6'h1C
`define PSTD_IDX_CABLE   6'h1E
`define PSTD_IDX_RST     6'h1F
// field positions
`define PSTD_BIT_LOCK    15
`define PSTD_BIT_DSTART  15
`define PSTD_BIT_SWRST   15
`define PSTD_BIT_RSTRT   14
`define PSTD_BIT_SATMODE 2
`define PSTD_BIT_DONE    1
`define PSTD_BIT_FAIL    0
// reset values and limits
`define PSTD_GAP_RST     8'h7D
`define PSTD_PKT_RST     11'h5DC
`define PSTD_MODE_RST    3'h0
`define PSTD_TALLY_MAX   8'hFF
`define PSTD_QUAL_RST    2'h0
`endif

//--- hw/pstd_pkg.sv
// types shared by the self-test/diag register group
package pstd_pkg;
    // cable measurement sequencing
    typedef enum logic [0:0] {
        DIAG_IDLE = 1'b0,
        DIAG_RUN  = 1'b1
    } pstd_diag_type;
    // link quality codes; zero carries no meaning
    typedef enum logic [1:0] {
        QUAL_NONE   = 2'b00,
        QUAL_GOOD   = 2'b01,
        QUAL_MEDIUM = 2'b10,
        QUAL_POOR   = 2'b11
    } pstd_qual_type;
endpackage

//--- hw/pstd_regs.sv
// self-test, cable diagnostic and reset control registers on a classic wishbone slave
`timescale 1ns/1ps
`default_nettype none
`include "pstd_map.svh"

module pstd_regs
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    input  wire logic        err_byte_i,
    input  wire logic        diag_done_i,
    input  wire logic        diag_fail_i,
    input  wire logic [1:0]  link_quality_i,
    output logic [1:0]       selftest_mode_o,
    output logic [7:0]       generator_gap_bytes_o,
    output logic [10:0]      generator_packet_bytes_o,
    output logic             diag_start_o,
    output logic             soft_reset_o,
    output logic             soft_restart_o
);

    // =========================================================
    // merge a 16-bit register with written byte lanes
    function automatic logic [15:0] lane_merge(input logic [15:0] old_v,
                                               input logic [31:0] wd,
                                               input logic [3:0]  sel);
        logic [15:0] res;
        res = old_v;
        if (sel[0])
        begin
            res[7:0] = wd[7:0];
        end
        if (sel[1])
        begin
            res[15:8] = wd[15:8];
        end
        return res;
    endfunction

    // =========================================================
    // bus slave state
    logic        ack_ff;
    logic        nxt_ack;
    logic [31:0] rdat_ff;
    logic [31:0] nxt_rdat;
    logic        req;
    logic        wr;
    logic        rd;
    logic [5:0]  idx;

    // =========================================================
    // register and block state
    logic [2:0]              mode_ff;
    logic [2:0]              nxt_mode;
    logic [7:0]              gap_ff;
    logic [7:0]              nxt_gap;
    logic [10:0]             pkt_ff;
    logic [10:0]             nxt_pkt;
    logic [7:0]              cnt_ff;
    logic [7:0]              nxt_cnt;
    logic [7:0]              view_ff;
    logic [7:0]              nxt_view;
    logic                    locked_ff;
    logic                    nxt_locked;
    pstd_pkg::pstd_diag_type diag_ff;
    pstd_pkg::pstd_diag_type nxt_diag;
    logic                    done_ff;
    logic                    nxt_done;
    logic                    fail_ff;
    logic                    nxt_fail;
    pstd_pkg::pstd_qual_type qual_ff;
    pstd_pkg::pstd_qual_type nxt_qual;
    logic                    swrst_ff;
    logic                    nxt_swrst;
    logic                    rstrt_ff;
    logic                    nxt_rstrt;
    logic                    rst_all;
    logic                    lock_wr;
    logic                    freeze_wr;
    logic                    start_wr;

    // request decode; ack rises one cycle after the request
    assign req = cyc_i && stb_i && !ack_ff;
    assign wr  = req && we_i;
    assign rd  = req && !we_i;
    assign idx = adr_i[7:2];
    assign rst_all = rst_i || swrst_ff;

    // write strobes that act beyond storing
    assign lock_wr   = wr && (idx == `PSTD_IDX_TALLY) && sel_i[1]
                       && dat_i[`PSTD_BIT_LOCK];
    assign freeze_wr = wr && (idx == `PSTD_IDX_MODE) && sel_i[0];
    assign start_wr  = wr && (idx == `PSTD_IDX_CABLE) && sel_i[1];

    // =========================================================
    // bus answer: read mux, unmapped reads give zero
    always_comb
    begin
        nxt_ack  = req;
        nxt_rdat = rdat_ff;
        if (rd)
        begin
            nxt_rdat = 32'h0000_0000;
            if (idx == `PSTD_IDX_MODE)
            begin
                nxt_rdat[2:0] = mode_ff;
            end
            else if (idx == `PSTD_IDX_TALLY)
            begin
                nxt_rdat[15:8] = view_ff;
                nxt_rdat[7:0]  = gap_ff;
            end
            else if (idx == `PSTD_IDX_PKT)
            begin
                nxt_rdat[10:0] = pkt_ff;
            end
            else if (idx == `PSTD_IDX_CABLE)
            begin
                nxt_rdat[`PSTD_BIT_DSTART] = diag_ff[0];
                nxt_rdat[9:8]              = qual_ff;
                nxt_rdat[`PSTD_BIT_DONE]   = done_ff;
                nxt_rdat[`PSTD_BIT_FAIL]   = fail_ff;
            end
            else
            begin
                nxt_rdat = 32'h0000_0000;
            end
        end
    end

    // bus flops live on the pin reset only so a reset write is acked
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_ff  <= 1'b0;
            rdat_ff <= 32'h0000_0000;
        end
        else
        begin
            ack_ff  <= nxt_ack;
            rdat_ff <= nxt_rdat;
        end
    end

    // =========================================================
    // configuration fields and reset controls
    always_comb
    begin
        logic [15:0] m;
        m         = 16'h0000;
        nxt_mode  = mode_ff;
        nxt_gap   = gap_ff;
        nxt_pkt   = pkt_ff;
        nxt_swrst = 1'b0;
        nxt_rstrt = 1'b0;
        if (wr && (idx == `PSTD_IDX_MODE))
        begin
            m        = lane_merge({13'h0000, mode_ff}, dat_i, sel_i);
            nxt_mode = m[2:0];
        end
        else if (wr && (idx == `PSTD_IDX_TALLY))
        begin
            m       = lane_merge({8'h00, gap_ff}, dat_i, sel_i);
            nxt_gap = m[7:0];
        end
        else if (wr && (idx == `PSTD_IDX_PKT))
        begin
            m       = lane_merge({5'h00, pkt_ff}, dat_i, sel_i);
            nxt_pkt = m[10:0];
        end
        else if (wr && (idx == `PSTD_IDX_RST) && sel_i[1])
        begin
            nxt_swrst = dat_i[`PSTD_BIT_SWRST];
            nxt_rstrt = dat_i[`PSTD_BIT_RSTRT];
        end
    end

    // software reset pulse clears itself after one cycle; only the pin reset resets its flop
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            swrst_ff <= 1'b0;
        end
        else
        begin
            swrst_ff <= nxt_swrst && !swrst_ff;
        end
    end

    // configuration flops; restart leaves them alone
    always_ff @(posedge clk_i)
    begin
        if (rst_all)
        begin
            mode_ff  <= `PSTD_MODE_RST;
            gap_ff   <= `PSTD_GAP_RST;
            pkt_ff   <= `PSTD_PKT_RST;
            rstrt_ff <= 1'b0;
        end
        else
        begin
            mode_ff  <= nxt_mode;
            gap_ff   <= nxt_gap;
            pkt_ff   <= nxt_pkt;
            rstrt_ff <= nxt_rstrt;
        end
    end

    // =========================================================
    // error tally: running counter and the shown value
    always_comb
    begin
        nxt_cnt    = cnt_ff;
        nxt_view   = view_ff;
        nxt_locked = locked_ff;
        if (err_byte_i)
        begin
            if (cnt_ff != `PSTD_TALLY_MAX || mode_ff[`PSTD_BIT_SATMODE])
            begin
                nxt_cnt = cnt_ff + 8'h01;
            end
        end
        if (lock_wr)
        begin
            nxt_view   = cnt_ff;
            nxt_cnt    = 8'h00;
            nxt_locked = 1'b1;
        end
        else if (freeze_wr)
        begin
            nxt_locked = 1'b1;
        end
        else if (locked_ff)
        begin
            if (rd && (idx == `PSTD_IDX_TALLY))
            begin
                nxt_locked = 1'b0;
            end
        end
        else
        begin
            nxt_view = cnt_ff;
        end
        if (rstrt_ff)
        begin
            nxt_cnt = 8'h00;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_all)
        begin
            cnt_ff    <= 8'h00;
            view_ff   <= 8'h00;
            locked_ff <= 1'b0;
        end
        else
        begin
            cnt_ff    <= nxt_cnt;
            view_ff   <= nxt_view;
            locked_ff <= nxt_locked;
        end
    end

    // =========================================================
    // cable measurement start, done, fail and quality
    always_comb
    begin
        nxt_diag = diag_ff;
        nxt_done = done_ff;
        nxt_fail = fail_ff;
        nxt_qual = qual_ff;
        if (start_wr)
        begin
            if (dat_i[`PSTD_BIT_DSTART])
            begin
                nxt_diag = pstd_pkg::DIAG_RUN;
                nxt_done = 1'b0;
                nxt_fail = 1'b0;
            end
            else
            begin
                nxt_diag = pstd_pkg::DIAG_IDLE;
            end
        end
        if (diag_ff == pstd_pkg::DIAG_RUN && diag_done_i)
        begin
            nxt_diag = pstd_pkg::DIAG_IDLE;
            nxt_done = 1'b1;
            nxt_fail = diag_fail_i;
            nxt_qual = pstd_pkg::pstd_qual_type'(link_quality_i);
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_all)
        begin
            diag_ff <= pstd_pkg::DIAG_IDLE;
            done_ff <= 1'b0;
            fail_ff <= 1'b0;
            qual_ff <= pstd_pkg::pstd_qual_type'(`PSTD_QUAL_RST);
        end
        else
        begin
            diag_ff <= nxt_diag;
            done_ff <= nxt_done;
            fail_ff <= nxt_fail;
            qual_ff <= nxt_qual;
        end
    end

    // outputs straight from flops
    assign dat_o                    = rdat_ff;
    assign ack_o                    = ack_ff;
    assign selftest_mode_o          = mode_ff[1:0];
    assign generator_gap_bytes_o    = gap_ff;
    assign generator_packet_bytes_o = pkt_ff;
    assign diag_start_o             = diag_ff[0];
    assign soft_reset_o             = swrst_ff;
    assign soft_restart_o           = rstrt_ff;

    // =========================================================
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_ack_single: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    a_tally_sat: assert property (
        (cnt_ff == 8'hFF && !mode_ff[2] && !lock_wr && !rstrt_ff && !swrst_ff)
        |=> cnt_ff == 8'hFF)
        else $error("tally wrapped in saturate mode");
    a_lock_clear: assert property (
        (lock_wr && !rstrt_ff) |=> (cnt_ff == 8'h00 && view_ff == $past(cnt_ff)))
        else $error("lock did not latch and clear");
    a_freeze_hold: assert property (
        (locked_ff && !lock_wr && !(rd && idx == 6'h1B) && !swrst_ff)
        |=> $stable(view_ff))
        else $error("frozen tally changed");
    a_gap_read: assert property (
        (rd && idx == 6'h1B) ##1 ack_o |-> dat_o[7:0] == generator_gap_bytes_o)
        else $error("gap readback mismatch");
    a_pkt_read: assert property (
        (rd && idx == 6'h1C) ##1 ack_o |-> (dat_o[31:11] == 21'h0
        && dat_o[10:0] == generator_packet_bytes_o))
        else $error("packet length readback wrong");
    a_start_launch: assert property (
        (start_wr && dat_i[15] && !swrst_ff && !(diag_start_o && diag_done_i))
        |=> diag_start_o && !done_ff)
        else $error("start write did not launch");
    a_done_clears: assert property (
        (diag_start_o && diag_done_i && !swrst_ff) |=> (!diag_start_o && done_ff
        && fail_ff == $past(diag_fail_i)))
        else $error("done did not clear start");
    a_done_holds: assert property (
        (!diag_start_o && !start_wr && !swrst_ff) |=> $stable(done_ff) && $stable(fail_ff))
        else $error("done or fail moved while idle");
    a_swrst_pulse: assert property (
        $rose(soft_reset_o) |=> (!soft_reset_o && generator_gap_bytes_o == 8'h7D
        && generator_packet_bytes_o == 11'h5DC && !diag_start_o))
        else $error("software reset incomplete");
    a_restart_keep: assert property (
        (soft_restart_o && !soft_reset_o) |=> (!soft_restart_o && cnt_ff == 8'h00
        && $stable(generator_gap_bytes_o)))
        else $error("restart disturbed registers");

    c_diag_done: cover property (diag_start_o ##[1:20] done_ff);
    c_tally_lock: cover property (err_byte_i ##1 lock_wr);
    c_soft_reset: cover property (soft_reset_o);

endmodule
`default_nettype wire

//--- test/phy_selftest_diag_reset_regs_tb_top.sv
// self-checking bench for the self-test, cable diagnostic and reset control registers
`timescale 1ns/1ps
`default_nettype none

module phy_selftest_diag_reset_regs_tb_top;
    // ==========================================================
    // stimulus and observed signals
    logic        clk_i          = 1'b0;
    logic        rst_i          = 1'b1;
    logic        cyc_i          = 1'b0;
    logic        stb_i          = 1'b0;
    logic        we_i           = 1'b0;
    logic [7:0]  adr_i          = 8'h00;
    logic [3:0]  sel_i          = 4'h0;
    logic [31:0] dat_i          = 32'h0;
    logic        err_byte_i     = 1'b0;
    logic        diag_done_i    = 1'b0;
    logic        diag_fail_i    = 1'b0;
    logic [1:0]  link_quality_i = 2'h0;
    logic [31:0] dat_o;
    logic        ack_o;
    logic [1:0]  selftest_mode_o;
    logic [7:0]  generator_gap_bytes_o;
    logic [10:0] generator_packet_bytes_o;
    logic        diag_start_o;
    logic        soft_reset_o;
    logic        soft_restart_o;
    int          miscompares    = 0;
    int          n_checks       = 0;
    int          n_rst          = 0;
    int          n_rstrt        = 0;

    // clock and pulse counters
    always #2.5 clk_i = ~clk_i;
    always @(posedge clk_i)
    begin
        if (soft_reset_o === 1'b1) n_rst++;
        if (soft_restart_o === 1'b1) n_rstrt++;
    end

    // ==========================================================
    // design under test
    pstd_regs uut (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .err_byte_i(err_byte_i), .diag_done_i(diag_done_i), .diag_fail_i(diag_fail_i),
        .link_quality_i(link_quality_i), .selftest_mode_o(selftest_mode_o),
        .generator_gap_bytes_o(generator_gap_bytes_o),
        .generator_packet_bytes_o(generator_packet_bytes_o),
        .diag_start_o(diag_start_o), .soft_reset_o(soft_reset_o),
        .soft_restart_o(soft_restart_o)
    );

    // ==========================================================
    // shared helpers
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    // one classic cycle; the request holds until ack is seen at an edge
    // the wait has no limit of its own: a missing ack is caught by the watchdog
    task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] s,
                       input logic [31:0] d, output logic [31:0] q);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        sel_i <= s;
        dat_i <= d;
        @(posedge clk_i);
        while (ack_o !== 1'b1)
        begin
            @(posedge clk_i);
        end
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, s, d, q);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 4'hF, 32'h0, q);
        check(q, exp);
    endtask

    // n consecutive error strobes, then time for the tally to settle
    task automatic errs(input int n);
        repeat (n)
        begin
            err_byte_i <= 1'b1;
            @(posedge clk_i);
        end
        err_byte_i <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask

    // ==========================================================
    // scenarios
    task automatic t_defaults;
        rd(8'h6C, 32'h007D);
        rd(8'h70, 32'h05DC);
        rd(8'h78, 32'h0000);
        rd(8'h7C, 32'h0000);
        check(32'(generator_gap_bytes_o), 32'h7D);
        check(32'(generator_packet_bytes_o), 32'h5DC);
    endtask

    task automatic t_tally;
        errs(5);
        rd(8'h6C, 32'h057D);
        wr(8'h6C, 4'h2, 32'h8000);
        errs(2);
        rd(8'h6C, 32'h057D);
        rd(8'h6C, 32'h027D);
        wr(8'h58, 4'h1, 32'h0001);
        check(32'(selftest_mode_o), 32'h1);
        errs(3);
        rd(8'h6C, 32'h027D);
        rd(8'h6C, 32'h057D);
    endtask

    task automatic t_saturate;
        errs(300);
        rd(8'h6C, 32'hFF7D);
        wr(8'h58, 4'h1, 32'h0004);
        check(32'(selftest_mode_o), 32'h0);
        wr(8'h6C, 4'h2, 32'h8000);
        rd(8'h6C, 32'hFF7D);
        errs(258);
        rd(8'h6C, 32'h027D);
    endtask

    task automatic t_fields;
        wr(8'h6C, 4'h1, 32'h0033);
        check(32'(generator_gap_bytes_o), 32'h33);
        wr(8'h6C, 4'h2, 32'h0055);
        rd(8'h6C, 32'h0233);
        wr(8'h70, 4'h3, 32'hFFFF);
        rd(8'h70, 32'h07FF);
        check(32'(generator_packet_bytes_o), 32'h7FF);
        wr(8'h78, 4'h3, 32'h7FFF);
        rd(8'h78, 32'h0000);
        wr(8'h7C, 4'h3, 32'h3FFF);
        rd(8'h7C, 32'h0000);
        wr(8'h00, 4'h3, 32'hFFFF);
        rd(8'h00, 32'h0000);
    endtask

    // quality codes one to three, with and without a failure
    task automatic t_diag;
        logic [1:0] pq;
        pq = 2'h0;
        for (int i = 1; i < 4; i++)
        begin
            wr(8'h78, 4'h2, 32'h8000);
            check(32'(diag_start_o), 32'h1);
            rd(8'h78, {16'h0, 1'b1, 5'h0, pq, 8'h00});
            diag_fail_i    <= i[0];
            link_quality_i <= i[1:0];
            diag_done_i    <= 1'b1;
            @(posedge clk_i);
            diag_done_i <= 1'b0;
            repeat (2) @(posedge clk_i);
            diag_fail_i    <= ~i[0];
            link_quality_i <= ~i[1:0];
            check(32'(diag_start_o), 32'h0);
            rd(8'h78, {22'h0, i[1:0], 6'h0, 1'b1, i[0]});
            rd(8'h78, {22'h0, i[1:0], 6'h0, 1'b1, i[0]});
            pq = i[1:0];
        end
        wr(8'h78, 4'h2, 32'h8000);
        wr(8'h78, 4'h2, 32'h0000);
        check(32'(diag_start_o), 32'h0);
        diag_done_i <= 1'b1;
        @(posedge clk_i);
        diag_done_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rd(8'h78, 32'h0300);
    endtask

    task automatic t_resets;
        errs(4);
        wr(8'h7C, 4'h2, 32'h4000);
        check(32'(n_rstrt), 32'h1);
        rd(8'h6C, 32'h0033);
        rd(8'h7C, 32'h0000);
        wr(8'h58, 4'h1, 32'h0003);
        wr(8'h7C, 4'h2, 32'h8000);
        repeat (2) @(posedge clk_i);
        check(32'(n_rst), 32'h1);
        check(32'(selftest_mode_o), 32'h0);
        rd(8'h6C, 32'h007D);
        rd(8'h70, 32'h05DC);
        rd(8'h78, 32'h0000);
        rd(8'h7C, 32'h0000);
    endtask

    // ==========================================================
    // verdict, main sequence and watchdog
    task automatic test_done;
        if (miscompares == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_defaults();
        t_tally();
        t_saturate();
        t_fields();
        t_diag();
        t_resets();
        test_done();
    end

    // the tests take under a thousand cycles; twenty thousand means a hang
    initial
    begin
        #100000;
        miscompares++;
        test_done();
    end
endmodule
`default_nettype wire
